/* File: pkg/ssp_pkg.sv */
// Purpose: Shared constants and types of the synchronous serial shift port.
// Assumes: The instruction-cycle clock is the block clock (100 MHz).
// Notes:   Shift-clock periods are given in instruction cycles.
package ssp_pkg;

  localparam int SSP_BITS = 8;
  localparam int SSP_TC_NS = 10;
  // Shift-clock periods in instruction cycles per rate setting
  localparam int SSP_PERIOD_TC_00 = 2;
  localparam int SSP_PERIOD_TC_01 = 4;
  localparam int SSP_PERIOD_TC_1X = 8;
  // Half periods in block clock cycles, derived from the periods
  localparam logic [2:0] SSP_HALF_00 = 3'(SSP_PERIOD_TC_00 / 2);
  localparam logic [2:0] SSP_HALF_01 = 3'(SSP_PERIOD_TC_01 / 2);
  localparam logic [2:0] SSP_HALF_1X = 3'(SSP_PERIOD_TC_1X / 2);
  // Edges of a full master transfer: two per bit
  localparam logic [4:0] SSP_EDGE_LAST = 5'(2 * SSP_BITS - 1);
  localparam logic [3:0] SSP_BIT_LAST = 4'(SSP_BITS - 1);

  typedef enum logic [0:0] {
    SSP_IDLE = 1'h0,
    SSP_SHIFT = 1'h1
  } ssp_state_type;

  typedef struct packed {
    logic portSelectBit;
    logic rateSelectHigh;
    logic rateSelectLow;
    logic outputPinConfig;
    logic clockPinConfig;
    logic phaseConfigBit;
    logic clockIdleLevel;
  } ssp_cfg_type;

  typedef struct packed {
    logic sckOut;
    logic sckOe;
    logic sdoOut;
    logic sdoOe;
  } ssp_pins_type;

  typedef struct packed {
    ssp_state_type state;
    logic [SSP_BITS-1:0] shiftReg;
    logic [3:0] bitCnt;
    logic [4:0] edgeCnt;
    logic [2:0] divCnt;
    logic sckLvl;
    logic sdo;
    logic irq;
    ssp_pins_type pins;
  } ssp_core_type;

  localparam ssp_core_type SSP_CORE_RST = '0;

endpackage

/* File: logic/ssp_in_sync.sv */
// Purpose: Three-flop synchroniser with filtered level and edge pulses.
// Assumes: Inputs are asynchronous pins.
// Notes:   A change counts once the second and third flops agree.
`timescale 1ns/1ps
module ssp_in_sync import ssp_pkg::*; #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic [W-1:0] pinIn,
  // Filtered results
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } ssp_sync_type;

  ssp_sync_type r;
  ssp_sync_type n;

  always_comb begin
    n = r;
    n.s1 = pinIn;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.rise = '0;
    n.fall = '0;
    for (int i = 0; i < W; i++) begin
      // The first flop feeds only the second; agreement uses s2 and s3
      if (r.s2[i] == r.s3[i] && r.s3[i] != r.lvl[i]) begin
        n.lvl[i] = r.s3[i];
        n.rise[i] = r.s3[i];
        n.fall[i] = ~r.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Level follows s3 as soon as s2 and s3 agree, a cycle ahead of the
  // edge pulses, so a master sample half a slow period after a change
  // already sees the new bit
  assign lvl = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.lvl);
  assign rise = r.rise;
  assign fall = r.fall;

endmodule // ssp_in_sync

/* File: logic/ssp_shift_port.sv */
// Purpose: Synchronous serial shift port, master or slave, 8-bit.
// Assumes: clk is the instruction-cycle clock; control bits are ports.
// Notes:   Slave shift clock and serial input are sampled by clk.
//
// What this block does
// - Eight-bit shift register fed from serial input, driving serial output.
// - Master makes the shift clock; slave takes it from outside.
// - Port active, pins driven, only while the port-select bit is one.
// - Master period is 2, 4 or 8 instruction cycles by rate bits.
// - Setting busy starts shifting; busy clears itself after eight bits.
// - Software clearing busy stops shifting at once, unless busy is set in the same cycle.
// - With interrupt enabled, completion of eight bits raises a request.
// - The master initiates every exchange; its clock pin is an output.
// - Output config drives or floats data; clock config picks master/slave.
// - After eight clock pulses busy clears and shifting stops.
// - Normal phase samples on rising edge, changes output on falling edge.
// - Alternate phase samples on falling edge, changes on rising edge.
// - Clock idle level follows the clock-pin data bit.
// - The phase-select flag is a cfg input, not reset here; zero is normal only with idle low.
// - Phase flag equal to idle level means normal, differing alternate.
`timescale 1ns/1ps
module ssp_shift_port import ssp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration bits
  input wire ssp_cfg_type cfg,
  input wire logic irqEnable,
  // Software access
  input wire logic loadStb,
  input wire logic [SSP_BITS-1:0] loadData,
  input wire logic busySet,
  input wire logic busyClear,
  output logic busyFlag,
  output logic [SSP_BITS-1:0] shiftData,
  output logic irqReq,
  // Serial pins
  input wire logic sdiPin,
  input wire logic sckPinIn,
  output logic sckPinOut,
  output logic sckPinOe,
  output logic sdoPinOut,
  output logic sdoPinOe
);

  ssp_core_type r;
  ssp_core_type n;
  logic [1:0] syncLvl;
  logic [1:0] syncRise;
  logic [1:0] syncFall;
  logic isMaster;
  logic sampleOnRise;
  logic [2:0] half;
  logic tick;
  logic sckUp;
  logic sckDown;
  logic sampleEvt;
  logic changeEvt;
  logic done;
  logic run;

  // Bit 1 is the shift clock, bit 0 the serial input. The level runs a
  // cycle ahead of the edge pulses; master receive is only sound at the
  // slow rate, where data changed half a period before the sample edge.
  ssp_in_sync #(.W(2)) uSync (
    .clk(clk),
    .rst(rst),
    .pinIn({sckPinIn, sdiPin}),
    .lvl(syncLvl),
    .rise(syncRise),
    .fall(syncFall)
  );

  always_comb begin
    n = r;
    n.irq = 1'b0;
    isMaster = cfg.clockPinConfig;
    // Equal flag and idle level select normal edges
    sampleOnRise = ~(cfg.phaseConfigBit ^ cfg.clockIdleLevel);
    if (cfg.rateSelectHigh) begin
      half = SSP_HALF_1X;
    end else if (cfg.rateSelectLow) begin
      half = SSP_HALF_01;
    end else begin
      half = SSP_HALF_00;
    end
    tick = 1'b0;
    sckUp = 1'b0;
    sckDown = 1'b0;
    run = (r.state == SSP_SHIFT) && cfg.portSelectBit;
    if (run && isMaster) begin
      if (r.divCnt == half - 3'h1) begin
        n.divCnt = '0;
        tick = 1'b1;
      end else begin
        n.divCnt = r.divCnt + 3'h1;
      end
      if (tick) begin
        n.sckLvl = ~r.sckLvl;
        sckUp = ~r.sckLvl;
        sckDown = r.sckLvl;
        n.edgeCnt = r.edgeCnt + 5'h1;
      end
    end else if (run) begin
      sckUp = syncRise[1];
      sckDown = syncFall[1];
    end
    sampleEvt = sampleOnRise ? sckUp : sckDown;
    changeEvt = sampleOnRise ? sckDown : sckUp;
    if (changeEvt) begin
      n.sdo = r.shiftReg[SSP_BITS-1];
    end
    if (sampleEvt) begin
      n.shiftReg = {r.shiftReg[SSP_BITS-2:0], syncLvl[0]};
      n.bitCnt = r.bitCnt + 4'h1;
    end
    // Master ends on the edge that returns the clock to idle
    if (isMaster) begin
      done = tick && (r.edgeCnt == SSP_EDGE_LAST);
    end else begin
      done = sampleEvt && (r.bitCnt == SSP_BIT_LAST);
    end
    if (loadStb) begin
      n.shiftReg = loadData;
    end
    unique case (r.state)
      SSP_IDLE: begin
        n.sckLvl = cfg.clockIdleLevel;
        n.sdo = n.shiftReg[SSP_BITS-1];
        if (busySet) begin
          n.state = SSP_SHIFT;
          n.bitCnt = '0;
          n.edgeCnt = '0;
          n.divCnt = '0;
        end
      end
      SSP_SHIFT: begin
        if (done) begin
          n.irq = irqEnable;
        end
        if (done || busyClear) begin
          n.state = SSP_IDLE;
          n.sckLvl = cfg.clockIdleLevel;
        end
        // A new start in the completing cycle wins over the clear
        if (busySet && done) begin
          n.state = SSP_SHIFT;
          n.bitCnt = '0;
          n.edgeCnt = '0;
          n.divCnt = '0;
        end else if (busySet) begin
          n.state = SSP_SHIFT;
        end
      end
    endcase
    n.pins.sckOut = n.sckLvl;
    n.pins.sckOe = cfg.portSelectBit && cfg.clockPinConfig;
    n.pins.sdoOut = n.sdo;
    n.pins.sdoOe = cfg.portSelectBit && cfg.outputPinConfig;
  end

  // Reset value clears all core state: shift register, counters, flags and pins
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= SSP_CORE_RST;
    end else begin
      r <= n;
    end
  end

  assign busyFlag = r.state[0];
  assign shiftData = r.shiftReg;
  assign irqReq = r.irq;
  assign sckPinOut = r.pins.sckOut;
  assign sckPinOe = r.pins.sckOe;
  assign sdoPinOut = r.pins.sdoOut;
  assign sdoPinOe = r.pins.sdoOe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_port_off_float: assert property (
    !cfg.portSelectBit |=> !sckPinOe && !sdoPinOe)
    else $error("pins driven while port not selected");
  a_sdo_cfg_drive: assert property (
    cfg.portSelectBit |=> sdoPinOe == $past(cfg.outputPinConfig))
    else $error("data pin enable does not follow config");
  a_master_clk_drive: assert property (
    cfg.portSelectBit |=> sckPinOe == $past(cfg.clockPinConfig))
    else $error("clock pin enable does not follow mode");
  a_sck_idle_level: assert property (
    !busyFlag |=> sckPinOut == $past(cfg.clockIdleLevel))
    else $error("clock not at idle level");
  a_abort_stops: assert property (
    busyFlag && busyClear && !busySet |=> !busyFlag ##1 $stable(shiftData)
      || $past(loadStb))
    else $error("software clear did not stop the transfer");
  a_irq_on_done: assert property (
    irqReq |-> $fell(busyFlag) || ($past(busySet) && busyFlag))
    else $error("interrupt without completion");
  a_rate_00_toggle: assert property (
    busyFlag && $past(busyFlag) && $past(busyFlag, 2) && cfg.portSelectBit
      && cfg.clockPinConfig && cfg.rateSelectHigh == 1'b0
      && cfg.rateSelectLow == 1'b0 && $stable(cfg)
      && $past(cfg) == $past(cfg, 2) |-> $changed(sckPinOut))
    else $error("fast master clock not toggling every cycle");
  a_master_sixteen: assert property (
    $fell(busyFlag) && $past(cfg.clockPinConfig) && !$past(busyClear)
      |-> $past(r.edgeCnt) == SSP_EDGE_LAST)
    else $error("master transfer ended before eight pulses");
  a_slave_eight: assert property (
    run && !isMaster && sampleEvt && r.bitCnt == SSP_BIT_LAST && !busySet
      |=> !busyFlag)
    else $error("slave busy not cleared after eighth bit");
  a_msb_first: assert property (
    sampleEvt && !loadStb |=> shiftData ==
      {$past(r.shiftReg[SSP_BITS-2:0]), $past(syncLvl[0])})
    else $error("shift register not moving toward msb");

  c_master_done: cover property (
    $fell(busyFlag) && cfg.clockPinConfig && !$past(busyClear));
  c_slave_done: cover property (
    $fell(busyFlag) && !cfg.clockPinConfig && !$past(busyClear));
  c_abort: cover property (busyFlag && busyClear ##1 !busyFlag);
  c_alt_phase: cover property (
    irqReq && (cfg.phaseConfigBit != cfg.clockIdleLevel));

endmodule // ssp_shift_port

/* File: dv/ssp_spi_peer.sv */
// Purpose: Behavioural far-side device of the serial link.
// Assumes: Edge roles are worked out by the bench from the config.
// Notes:   Its clock stands still outside frames.
`timescale 1ns/1ps
module ssp_spi_peer (
  // Link
  input wire logic sckLine,
  input wire logic sdoLine,
  output logic sckDrv,
  output logic sdiOut,
  // Edge roles and result
  input wire logic sampleRise,
  input wire logic firstChange,
  output logic [7:0] rxByte
);
  logic [7:0] tx;
  initial begin
    sckDrv = 1'b0;
    sdiOut = 1'b0;
    rxByte = 8'h00;
    tx = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    tx = b;
    sdiOut = b[7];
  endtask
  task automatic park(input logic lvl);
    sckDrv = lvl;
  endtask
  // Eight pulses of 125 ns, each level held well above three cycles
  task automatic frame(input logic idle);
    repeat (8) begin
      #62.5 sckDrv = ~idle;
      #62.5 sckDrv = idle;
    end
  endtask
  always @(sckLine) begin
    if (sckLine === sampleRise) begin
      rxByte = {rxByte[6:0], sdoLine};
    end else begin
      // A leading change edge must put out the msb, not skip it
      if (!firstChange) tx = tx << 1;
      sdiOut = tx[7];
      if (firstChange) tx = tx << 1;
    end
  end
endmodule // ssp_spi_peer

/* File: dv/ssp_shift_port_tb_top.sv */
// Purpose: Self-checking bench of the serial shift port.
// Assumes: Control inputs change at the falling clock edge; link pins follow the peer.
// Notes:   Master receive data is only checked at the slow rate.
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  $display("unexpected %s exp %0h got %0h", n, e, a); \
  errCount++; end end
module ssp_shift_port_tb_top import ssp_pkg::*; ;
  logic clk = 0, rst = 1, irqEnable = 0, loadStb = 0;
  logic busySet = 0, busyClear = 0, sdoLast = 0;
  ssp_cfg_type cfg = '0;
  logic [7:0] loadData = 8'h00, shiftData, rxByte;
  logic busyFlag, irqReq, sckPinOut, sckPinOe, sdoPinOut, sdoPinOe;
  logic sckDrv, sdiOut, sckLine, sdoLine;
  int errCount = 0, compares = 0, busyCnt = 0, irqCnt = 0;
  int per [4] = '{SSP_PERIOD_TC_00, SSP_PERIOD_TC_01,
    SSP_PERIOD_TC_1X, SSP_PERIOD_TC_1X};
  assign sckLine = sckPinOe ? sckPinOut : sckDrv;
  // A released data line shows the inverse of its last value
  assign sdoLine = sdoPinOe ? sdoPinOut : ~sdoLast;
  ssp_shift_port ssp_shift_port_inst (.clk(clk), .rst(rst), .cfg(cfg),
    .irqEnable(irqEnable), .loadStb(loadStb), .loadData(loadData),
    .busySet(busySet), .busyClear(busyClear), .busyFlag(busyFlag),
    .shiftData(shiftData), .irqReq(irqReq), .sdiPin(sdiOut),
    .sckPinIn(sckLine), .sckPinOut(sckPinOut), .sckPinOe(sckPinOe),
    .sdoPinOut(sdoPinOut), .sdoPinOe(sdoPinOe));
  ssp_spi_peer ssp_spi_peer_inst (.sckLine(sckLine), .sdoLine(sdoLine),
    .sckDrv(sckDrv), .sdiOut(sdiOut),
    .sampleRise(~(cfg.phaseConfigBit ^ cfg.clockIdleLevel)),
    .firstChange(cfg.phaseConfigBit), .rxByte(rxByte));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sdoPinOe === 1'b1) sdoLast <= sdoPinOut;
    if (busyFlag === 1'b1) busyCnt <= busyCnt + 1;
    if (irqReq === 1'b1) irqCnt <= irqCnt + 1;
  end
  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bits: select, rate high, rate low, out cfg, clock cfg, phase, idle
  task automatic setCfg(input logic [6:0] c);
    @(negedge clk);
    cfg = c;
    ssp_spi_peer_inst.park(c[0]);
    repeat (2) @(negedge clk);
  endtask
  task automatic xfer(input logic [7:0] d, p, input logic slv);
    int i;
    ssp_spi_peer_inst.put(p);
    @(negedge clk);
    loadData = d;
    loadStb = 1;
    @(negedge clk);
    loadStb = 0;
    busySet = 1;
    busyCnt = 0;
    irqCnt = 0;
    @(negedge clk);
    busySet = 0;
    if (slv) ssp_spi_peer_inst.frame(cfg.clockIdleLevel);
    for (i = 0; i < 300 && busyFlag !== 1'b0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  initial begin
    #100us;
    errCount++;
    summarize();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    `CHK("busyRst", 1'b0, busyFlag)
    `CHK("oeRst", 2'b00, {sckPinOe, sdoPinOe})
    setCfg(7'b0001100);
    `CHK("oeOff", 2'b00, {sckPinOe, sdoPinOe})
    setCfg(7'b1000100);
    `CHK("oeSplit", 2'b10, {sckPinOe, sdoPinOe})
    $display("test pins done");
    for (int r = 0; r < 4; r++) begin
      irqEnable = r[0];
      setCfg({1'b1, 2'(r), 4'b1100});
      xfer(8'hA5, 8'h3C, 1'b0);
      `CHK("busyCycles", SSP_BITS * per[r], busyCnt)
      `CHK("peerRx", 8'hA5, rxByte)
      `CHK("irqCount", int'(r[0]), irqCnt)
      $display("test rate %0d done", r);
    end
    for (int k = 0; k < 8; k++) begin
      setCfg({1'b1, 2'b10, 1'b1, ~k[2], 2'(k)});
      xfer(8'h5A ^ 8'(k), 8'hC3 ^ 8'(k), k[2]);
      `CHK("peerRx", 8'h5A ^ 8'(k), rxByte)
      `CHK("shiftData", 8'hC3 ^ 8'(k), shiftData)
      `CHK("sckIdle", k[0], sckLine)
      `CHK("sckOe", ~k[2], sckPinOe)
      `CHK("busyDone", 1'b0, busyFlag)
      $display("test phase %0d done", k);
    end
    setCfg(7'b1101100);
    irqEnable = 1;
    busySet = 1;
    irqCnt = 0;
    @(negedge clk);
    busySet = 0;
    repeat (20) @(negedge clk);
    busyClear = 1;
    @(negedge clk);
    busyClear = 0;
    `CHK("busyAbort", 1'b0, busyFlag)
    @(negedge clk);
    `CHK("sckAbort", 1'b0, sckPinOut)
    repeat (80) @(negedge clk);
    `CHK("irqAbort", 0, irqCnt)
    $display("test abort done");
    summarize();
  end
endmodule // ssp_shift_port_tb_top
